// *** core/pfm_defines.svh ***
// Timing and reset constants for the mains-fail monitor
`ifndef PFM_DEFINES_SVH
`define PFM_DEFINES_SVH

// ----------------------------------------
// Clock
// ----------------------------------------
`define PFM_CLK_HZ 100000000
`define PFM_US_TO_CYC(us) ((us) * (`PFM_CLK_HZ / 1000000))

// ----------------------------------------
// Sequence times, in microseconds, and the phase tolerance
// ----------------------------------------
`define PFM_RESTART_US 525000
`define PFM_RELEASE_US 225000
`define PFM_LOSS_MAX_US 50000
`define PFM_SETTLE_US 10000
`define PFM_HALF_US 8333
`define PFM_PHASE_TOL_PCT 100

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PFM_SYNC_RST 1'b0
`define PFM_LINESYNC_IDLE 1'b1

`endif

// *** core/pfm_pkg.sv ***
// Types shared by the mains-fail monitor modules
package pfm_pkg;
	typedef enum logic [1:0] {
		PFM_RUN,
		PFM_FAIL,
		PFM_DOWN,
		PFM_RECOVER
	} pfm_state_t;
endpackage

// *** core/pfm_pin_if.sv ***
// Carrier for raw pin levels and their synchronised copies
`timescale 1ns/1ps
interface pfm_pin_if #(parameter int W = 3) ();
	logic [W-1:0] raw;
	logic [W-1:0] clean;
	modport syncer (input raw, output clean);
	modport user (output raw, input clean);
endinterface

// *** core/pfm_sync.sv ***
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`include "pfm_defines.svh"
module pfm_sync #(parameter int W = 3) (
	input wire logic ref_clk,
	input wire logic nrst,
	pfm_pin_if.syncer pins
);
	logic [W-1:0] f1;
	logic [W-1:0] f2;
	logic [W-1:0] f3;
	logic [W-1:0] clean;
	logic [W-1:0] next_clean;

	// ----------------------------------------
	// Filter
	// ----------------------------------------
	// f1 feeds only f2; a change is taken once f2 and f3 agree
	always_comb begin
		for (int i = 0; i < W; i++) begin
			next_clean[i] = (f2[i] == f3[i]) ? f3[i] : clean[i];
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			f1 <= {W{`PFM_SYNC_RST}};
			f2 <= {W{`PFM_SYNC_RST}};
			f3 <= {W{`PFM_SYNC_RST}};
			clean <= {W{`PFM_SYNC_RST}};
		end else begin
			f1 <= pins.raw;
			f2 <= f1;
			f3 <= f2;
			clean <= next_clean;
		end
	end

	assign pins.clean = clean;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_sync_agree: assert property (@(posedge ref_clk) disable iff (!nrst)
		$changed(clean) |-> $past(f2) == $past(f3))
		else $error("synchronised input changed without agreement");
endmodule // pfm_sync

// *** core/pfm_top.sv ***
// Mains-fail monitor: fail and restart line sequencing, standby switch, line sync
// Contract
// - Mains loss drives every mains-loss line low with no deliberate delay.
// - Mains-loss lines release within 50 ms once mains and supply both recover.
// - Restart lines go low 525 ms after the mains-loss lines fall.
// - Restart lines go high 225 ms after mains and supply both recover.
// - Every copy of both line groups has its own driver.
// - Standby rail switches on at mains failure, off at power-up.
// - Line sync comes from the crystal, locked to mains reference points.
// - Line sync is a 50 percent square wave with 8.333 ms halves.
// - Line sync bridges missing reference pulses and ignores line noise.
// - Line sync stops while restart is low and resumes on release.
`timescale 1ns/1ps
`include "pfm_defines.svh"
module pfm_top #(
	parameter int NLOSS = 2,
	parameter int NRESTART = 2,
	parameter int unsigned RESTART_CYC = `PFM_US_TO_CYC(`PFM_RESTART_US),
	parameter int unsigned RELEASE_CYC = `PFM_US_TO_CYC(`PFM_RELEASE_US),
	parameter int unsigned SETTLE_CYC = `PFM_US_TO_CYC(`PFM_SETTLE_US),
	parameter int unsigned HALF_CYC = `PFM_US_TO_CYC(`PFM_HALF_US)
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic mains_ok,
	input wire logic supply_ok,
	input wire logic phase_ref,
	output logic [NLOSS-1:0] mains_loss_flag_n,
	output logic [NRESTART-1:0] restart_n,
	output logic standby_on,
	output logic linesync
);
	localparam logic [31:0] RESTART_LAST = 32'(RESTART_CYC - 1);
	localparam logic [31:0] RELEASE_LAST = 32'(RELEASE_CYC - 1);
	localparam logic [31:0] SETTLE_LAST = 32'(SETTLE_CYC - 1);
	localparam logic [31:0] HALF_LAST = 32'(HALF_CYC - 1);
	localparam logic [31:0] WIN = 32'(HALF_CYC / `PFM_PHASE_TOL_PCT);
	localparam logic [31:0] EARLY = 32'(HALF_CYC - HALF_CYC / `PFM_PHASE_TOL_PCT);

	// ----------------------------------------
	// Input synchronisation
	// ----------------------------------------
	pfm_pin_if #(.W(3)) pins ();
	assign pins.raw = {phase_ref, supply_ok, mains_ok};

	pfm_sync #(.W(3)) u_sync (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.pins(pins)
	);

	logic mains_loss_signal;
	logic recovered;
	logic ph;
	assign mains_loss_signal = ~pins.clean[0];
	assign recovered = pins.clean[0] & pins.clean[1];
	assign ph = pins.clean[2];

	// ----------------------------------------
	// Power sequence
	// ----------------------------------------
	pfm_pkg::pfm_state_t state;
	pfm_pkg::pfm_state_t next_state;
	logic [31:0] cnt;
	logic [31:0] next_cnt;
	logic loss;
	logic next_loss;
	logic rst_act;
	logic next_rst_act;
	logic next_standby;

	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_loss = loss;
		next_rst_act = rst_act;
		next_standby = standby_on;
		case (state)
			pfm_pkg::PFM_RUN: begin
				if (mains_loss_signal) begin
					next_state = pfm_pkg::PFM_FAIL;
					next_cnt = '0;
					next_loss = 1'b1;
					next_standby = 1'b1;
				end
			end
			pfm_pkg::PFM_FAIL: begin
				if (recovered) begin
					next_state = pfm_pkg::PFM_RECOVER;
					next_cnt = '0;
				end else if (cnt >= RESTART_LAST) begin
					next_state = pfm_pkg::PFM_DOWN;
					next_rst_act = 1'b1;
				end else begin
					next_cnt = cnt + 32'h1;
				end
			end
			pfm_pkg::PFM_DOWN: begin
				if (recovered) begin
					next_state = pfm_pkg::PFM_RECOVER;
					next_cnt = '0;
				end
			end
			pfm_pkg::PFM_RECOVER: begin
				// Any dip while counting restarts the whole recovery
				if (!recovered) begin
					next_state = rst_act ? pfm_pkg::PFM_DOWN : pfm_pkg::PFM_FAIL;
					next_cnt = '0;
					next_loss = 1'b1;
					next_standby = 1'b1;
				end else begin
					next_cnt = cnt + 32'h1;
					if (cnt >= SETTLE_LAST) begin
						next_loss = 1'b0;
					end
					if (cnt >= RELEASE_LAST) begin
						next_state = pfm_pkg::PFM_RUN;
						next_rst_act = 1'b0;
						next_standby = 1'b0;
					end
				end
			end
			default: begin
				next_state = pfm_pkg::PFM_DOWN;
			end
		endcase
	end

	// Power-up counts as a failure so the sequence starts from restart held
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state <= pfm_pkg::PFM_DOWN;
			cnt <= '0;
			loss <= 1'b1;
			rst_act <= 1'b1;
			standby_on <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			loss <= next_loss;
			rst_act <= next_rst_act;
			standby_on <= next_standby;
		end
	end

	// ----------------------------------------
	// Output line drivers
	// ----------------------------------------
	// One flop per copy, so a shorted line cannot pull down its siblings
	genvar gi;
	for (gi = 0; gi < NLOSS; gi++) begin : g_loss
		always_ff @(posedge ref_clk or negedge nrst) begin
			if (!nrst) begin
				mains_loss_flag_n[gi] <= 1'b0;
			end else begin
				mains_loss_flag_n[gi] <= ~next_loss;
			end
		end
	end
	for (gi = 0; gi < NRESTART; gi++) begin : g_restart
		always_ff @(posedge ref_clk or negedge nrst) begin
			if (!nrst) begin
				restart_n[gi] <= 1'b0;
			end else begin
				restart_n[gi] <= ~next_rst_act;
			end
		end
	end

	// ----------------------------------------
	// Line sync
	// ----------------------------------------
	logic ph_d;
	logic ref_rise;
	logic [31:0] pcnt;
	logic [31:0] next_pcnt;
	logic next_linesync;
	assign ref_rise = ph & ~ph_d;

	// Reference edges only count within 1 percent of the expected point
	always_comb begin
		next_pcnt = pcnt + 32'h1;
		next_linesync = linesync;
		if (rst_act) begin
			next_pcnt = '0;
			next_linesync = `PFM_LINESYNC_IDLE;
		end else if (ref_rise && pcnt >= EARLY) begin
			next_pcnt = '0;
			next_linesync = ~linesync;
		end else if (ref_rise && pcnt < WIN) begin
			next_pcnt = '0;
		end else if (pcnt >= HALF_LAST) begin
			next_pcnt = '0;
			next_linesync = ~linesync;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ph_d <= 1'b0;
			pcnt <= '0;
			linesync <= `PFM_LINESYNC_IDLE;
		end else begin
			ph_d <= ph;
			pcnt <= next_pcnt;
			linesync <= next_linesync;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	a_loss_immediate: assert property (
		state == pfm_pkg::PFM_RUN && mains_loss_signal |=> mains_loss_flag_n == '0 && standby_on)
		else $error("mains-loss lines late after mains loss");
	a_loss_release: assert property (
		$rose(mains_loss_flag_n[0]) |-> $past(recovered) && $past(cnt) >= SETTLE_LAST)
		else $error("mains-loss lines released without recovery");
	a_loss_bound: assert property (
		state == pfm_pkg::PFM_RECOVER && recovered && cnt == SETTLE_LAST |=> mains_loss_flag_n[0])
		else $error("mains-loss lines not released in time");
	a_restart_delay: assert property (
		$fell(restart_n[0]) |-> $past(state) == pfm_pkg::PFM_FAIL && $past(cnt) == RESTART_LAST)
		else $error("restart fell at wrong time");
	a_restart_release: assert property (
		$rose(restart_n[0]) |-> $past(cnt) == RELEASE_LAST && !standby_on)
		else $error("restart released at wrong time");
	a_copies_agree: assert property (
		(mains_loss_flag_n == '0 || &mains_loss_flag_n) && (restart_n == '0 || &restart_n))
		else $error("line copies disagree");
	a_standby_on: assert property ($fell(mains_loss_flag_n[0]) |-> standby_on)
		else $error("standby not on at failure");
	a_sync_edge: assert property (
		restart_n[0] && $changed(linesync) |-> $past(ref_rise) || $past(pcnt) == HALF_LAST)
		else $error("line sync toggled without cause");
	a_half_bridge: assert property (
		!rst_act && !ref_rise && pcnt == HALF_LAST |=> $changed(linesync) && pcnt == '0)
		else $error("missing reference not bridged");
	a_half_max: assert property (pcnt <= HALF_LAST)
		else $error("half cycle overran");
	a_stop_hold: assert property (restart_n[0] == 1'b0 |=> linesync == `PFM_LINESYNC_IDLE && pcnt == '0)
		else $error("line sync running during restart");

	c_full_outage: cover property (state == pfm_pkg::PFM_DOWN ##1 state == pfm_pkg::PFM_RECOVER);
	c_brief_dip: cover property (state == pfm_pkg::PFM_FAIL ##1 state == pfm_pkg::PFM_RECOVER);
	c_ref_lock: cover property (ref_rise && pcnt >= EARLY && !rst_act);
	c_bridge: cover property (!rst_act && !ref_rise && pcnt == HALF_LAST);
endmodule // pfm_top

// *** verification/pfm_cpu_model.sv ***
// Receiving module logic that watches the mains-loss and restart line copies
`timescale 1ns/1ps
module pfm_cpu_model #(parameter int NL = 2, parameter int NR = 2) (
	input wire logic ref_clk,
	input wire logic [NL-1:0] loss_n,
	input wire logic [NR-1:0] restart_n,
	output logic copy_err,
	output logic held
);
	initial copy_err = 1'b0;
	// A shared or broken driver shows up as copies that disagree
	always @(posedge ref_clk) begin
		if ((loss_n != '0 && loss_n != '1) || (restart_n != '0 && restart_n != '1)) begin
			copy_err <= 1'b1;
		end
	end
	assign held = ~&restart_n;
endmodule // pfm_cpu_model

// *** verification/pfm_tb_top.sv ***
// Self-checking bench for the mains-fail monitor
`timescale 1ns/1ps
`define CHK(a, b, m) begin n_tests++; if ((a) !== (b)) begin err_count++; $display("FAIL t=%0t %s", $time, m); end end
module pfm_tb_top;
	localparam int RC = 60;
	localparam int RL = 30;
	localparam int SC = 5;
	localparam int HC = 1000;
	typedef struct {logic [4:0] v; int lo; int hi;} pfm_note_t;
	logic ref_clk, nrst, mains_ok, supply_ok, phase_ref, standby_on, linesync, copy_err, held, ls_d;
	logic [1:0] loss_n, rs_n;
	logic [4:0] grp, grp_d;
	int cyc, err_count, n_tests, last_ls, t, r;
	pfm_note_t q[$];
	pfm_note_t lsq[$];
	assign grp = {loss_n, rs_n, standby_on};
	pfm_top #(.RESTART_CYC(RC), .RELEASE_CYC(RL), .SETTLE_CYC(SC), .HALF_CYC(HC)) dut_u (.ref_clk(ref_clk),
		.nrst(nrst), .mains_ok(mains_ok), .supply_ok(supply_ok), .phase_ref(phase_ref),
		.mains_loss_flag_n(loss_n), .restart_n(rs_n), .standby_on(standby_on), .linesync(linesync));
	pfm_cpu_model cpu_u (.ref_clk(ref_clk), .loss_n(loss_n), .restart_n(rs_n), .copy_err(copy_err), .held(held));
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// ----------------------------------------
	// Monitor: every line change must match the oldest note
	// ----------------------------------------
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		grp_d <= grp;
		ls_d <= linesync;
		if (nrst && grp !== grp_d) begin
			if (q.size() == 0) begin
				`CHK(1'b0, 1'b1, "unexpected line change")
			end else begin
				`CHK(grp, q[0].v, "line levels")
				`CHK(cyc >= q[0].lo && cyc <= q[0].hi, 1'b1, "line timing")
				void'(q.pop_front());
			end
		end
		if (!held && linesync !== ls_d) begin
			if (lsq.size() > 0) begin
				`CHK(cyc - last_ls >= lsq[0].lo && cyc - last_ls <= lsq[0].hi, 1'b1, "sync half")
				void'(lsq.pop_front());
			end
			last_ls = cyc;
		end
	end
	task automatic idle(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic pins(input logic m, input logic s);
		@(posedge ref_clk);
		mains_ok <= m;
		supply_ok <= s;
		t = cyc;
	endtask
	// Pin sync adds a few edges, so each note is a short window
	task automatic expect_at(input logic [4:0] v, input int d);
		q.push_back('{v, t + d + 3, t + d + 8});
	endtask
	task automatic drain();
		int i;
		for (i = 0; i < 3000 && q.size() > 0; i++) begin
			@(posedge ref_clk);
		end
		`CHK(q.size(), 0, "missing line change")
	endtask
	task automatic pulse(input int at);
		idle(at);
		phase_ref <= 1'b1;
		idle(6);
		phase_ref <= 1'b0;
	endtask
	task automatic wait_ls();
		logic v;
		int i;
		v = linesync;
		for (i = 0; i < HC + 50 && linesync === v; i++) begin
			@(posedge ref_clk);
		end
		`CHK(linesync, ~v, "sync edge")
		// Let the monitor take this edge first, so the next half note is not consumed by it
		@(negedge ref_clk);
	endtask
	task automatic end_of_test();
		`CHK(copy_err, 1'b0, "copies split")
		$display("errors %0d checks %0d", err_count, n_tests);
		if (err_count == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge ref_clk);
		err_count++;
		end_of_test();
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{nrst, mains_ok, supply_ok, phase_ref} = 4'h0;
		{cyc, err_count, n_tests, last_ls, t} = '0;
		grp_d = 5'h00;
		ls_d = 1'b1;
		void'($urandom(32'h7A8CE54B));
		idle(4);
		nrst <= 1'b1;
		idle(2);
		`CHK(grp, 5'h00, "reset levels")
		`CHK(linesync, 1'b1, "sync idle")
		pins(1'b1, 1'b1);
		expect_at(5'h18, SC);
		expect_at(5'h1E, RL);
		drain();
		// Supply dip alone while running must not move any line
		pins(1'b1, 1'b0);
		idle(40);
		pins(1'b1, 1'b1);
		wait_ls();
		lsq.push_back('{5'h00, HC - 1, HC + 1});
		r = 100 + $urandom % 700;
		pulse(r);
		wait_ls();
		lsq.push_back('{5'h00, HC + 2, HC + 12});
		pulse(1);
		wait_ls();
		lsq.push_back('{5'h00, HC - 14, HC - 2});
		pulse(HC - 12);
		lsq.push_back('{5'h00, HC - 1, HC + 1});
		wait_ls();
		// Recovery before restart falls: restart must never drop
		pins(1'b0, 1'b1);
		expect_at(5'h07, 0);
		idle(20);
		pins(1'b1, 1'b1);
		expect_at(5'h1F, SC);
		expect_at(5'h1E, RL);
		drain();
		pins(1'b0, 1'b1);
		expect_at(5'h07, 0);
		expect_at(5'h01, RC);
		drain();
		idle(2);
		`CHK(linesync, 1'b1, "sync stopped")
		// Supply loss in mid-recovery starts the wait again
		pins(1'b1, 1'b1);
		expect_at(5'h19, SC);
		drain();
		pins(1'b1, 1'b0);
		expect_at(5'h01, 0);
		drain();
		pins(1'b1, 1'b1);
		expect_at(5'h19, SC);
		expect_at(5'h1E, RL);
		drain();
		wait_ls();
		end_of_test();
	end
endmodule // pfm_tb_top
